//--- hw/rtmc_mode_opt.sv
`timescale 1ns/1ps
`include "rtmc_defines.svh"

module rtmc_mode_opt
  import rtmc_pkg::*;
(
  // Clock and reset.
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,

  // Device pins, asynchronous to the clock.
  input  wire logic                     i_master_reset_n,
  input  wire logic [4:0]               i_terminal_address,
  input  wire logic                     i_terminal_address_parity,
  input  wire logic                     i_address_lock,

  // Host register access.
  input  wire logic                     i_reg_wr,
  input  wire logic                     i_reg_rd,
  input  wire logic [`RTMC_ADDR_W-1:0]  i_reg_addr,
  input  wire logic [`RTMC_DATA_W-1:0]  i_reg_wdata,
  output logic      [`RTMC_DATA_W-1:0]  o_reg_rdata,
  output logic                          o_reg_rvalid,

  // Host terminal software reset request.
  input  wire logic                     i_terminal_soft_reset,

  // Received mode command from the protocol engine.
  input  wire logic                     i_mc_valid,
  input  wire logic [4:0]               i_mc_code,
  input  wire logic                     i_mc_broadcast,
  input  wire logic [`RTMC_DATA_W-1:0]  i_mc_data,
  output logic                          o_mc_busy,

  // Status word transmission handshake.
  output logic                          o_status_go,
  input  wire logic                     i_status_done,

  // Actions towards the rest of the terminal.
  output logic                          o_ttag_load,
  output logic      [`RTMC_DATA_W-1:0]  o_ttag_data,
  output logic                          o_sr_clear,
  output logic                          o_soft_reset_pulse,

  // Device owned low field of the operational status register.
  input  wire logic                     i_low_status_we,
  input  wire logic [`RTMC_OPS_LOW_W-1:0] i_low_status,

  // Terminal address as held in the status register.
  output logic      [4:0]               o_terminal_address,
  output logic                          o_address_parity_err
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic [7:0]              pins_sync;
  logic                    mr_n_sync;
  logic                    mr_n_prev_ff;
  logic                    mr_rise;
  logic                    mr_low;
  logic [`RTMC_DATA_W-1:0] opstat_value;
  logic                    opstat_wr;

  logic [3:0]              optcfg_ff;
  rtmc_sync_opt_t          sync_load_option;
  logic                    vector_cmd_sr_option;
  logic                    reset_cmd_option;

  rtmc_state_t             state_ff;
  rtmc_state_t             nxt_state;
  logic [4:0]              code_ff;
  logic                    bcast_ff;
  logic [`RTMC_DATA_W-1:0] data_ff;
  logic                    go_sent_ff;
  logic                    mc_known;

  logic                    ttag_load_ff;
  logic [`RTMC_DATA_W-1:0] ttag_data_ff;
  logic                    sr_clear_ff;
  logic                    soft_reset_ff;
  logic                    status_go_ff;
  logic                    busy_ff;
  logic [`RTMC_DATA_W-1:0] rdata_ff;
  logic                    rvalid_ff;
  logic [4:0]              addr_ff;
  logic                    parity_err_ff;

  // --------------------------------------------------------------------------
  // Decoding helpers
  // --------------------------------------------------------------------------
  // Decides whether a synchronize data word may reach the time tag counter.
  function automatic logic sync_load_ok(input rtmc_sync_opt_t opt,
                                        input logic           bit0);
    logic ok;
    ok = 1'b0;
    unique case (opt)
      RTMC_SYNC_HOST:   ok = 1'b0;
      RTMC_SYNC_IF_LOW: ok = !bit0;
      RTMC_SYNC_IF_HI:  ok = bit0;
      RTMC_SYNC_ALWAYS: ok = 1'b1;
    endcase
    return ok;
  endfunction : sync_load_ok
  // Picks out the mode codes that this block acts upon.
  function automatic logic is_handled_code(input logic [4:0] code);
    return (code == `RTMC_MC_RESET_RT) || (code == `RTMC_MC_TX_VECTOR) ||
           (code == `RTMC_MC_SYNC_DATA);
  endfunction : is_handled_code

  // --------------------------------------------------------------------------
  // Pin synchronisation and master reset edge
  // --------------------------------------------------------------------------
  // All pins come from outside the clock domain, so each is synchronised.
  rtmc_pin_sync #(
    .WIDTH (8)
  ) u_pin_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async ({i_master_reset_n, i_terminal_address,
               i_terminal_address_parity, i_address_lock}),
    .o_sync  (pins_sync)
  );

  assign mr_n_sync = pins_sync[7];
  // The previous level lets us see the release of master reset.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mr_n_prev_ff <= 1'b0;
    end else begin
      mr_n_prev_ff <= mr_n_sync;
    end
  end

  // The edge uses the pin levels synchronised on the same cycles, so the
  // captured address matches what was strapped when the pin rose.
  assign mr_rise = mr_n_sync && !mr_n_prev_ff;
  assign mr_low  = !mr_n_sync;

  // --------------------------------------------------------------------------
  // Operational status register
  // --------------------------------------------------------------------------
  assign opstat_wr = i_reg_wr && (i_reg_addr == `RTMC_OPSTAT_ADDR);

  rtmc_opstat_reg u_opstat (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_mr_low     (mr_low),
    .i_mr_rise    (mr_rise),
    .i_pin_levels (pins_sync[6:0]),
    .i_wr         (opstat_wr),
    .i_wr_data    (i_reg_wdata),
    .i_low_we     (i_low_status_we),
    .i_low_data   (i_low_status),
    .o_value      (opstat_value)
  );

  // Address copy and odd parity check over address plus parity bit.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      addr_ff       <= 5'h00;
      parity_err_ff <= 1'b0;
    end else begin
      addr_ff       <= opstat_value[`RTMC_OPS_ADDR_HI:`RTMC_OPS_ADDR_LO];
      parity_err_ff <= !(^opstat_value[`RTMC_OPS_ADDR_HI:`RTMC_OPS_PARITY_BIT]);
    end
  end

  // --------------------------------------------------------------------------
  // Mode command option register
  // --------------------------------------------------------------------------
  // The options are device configuration, so the master reset pin clears them
  // while a terminal software reset leaves them as the host set them.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      optcfg_ff <= `RTMC_OPTCFG_RESET;
    end else if (mr_low) begin
      optcfg_ff <= `RTMC_OPTCFG_RESET;
    end else if (i_reg_wr && (i_reg_addr == `RTMC_OPTCFG_ADDR)) begin
      optcfg_ff <= i_reg_wdata[3:0];
    end
  end

  assign sync_load_option     =
    rtmc_sync_opt_t'(optcfg_ff[`RTMC_OPT_SYNC_HI:`RTMC_OPT_SYNC_LO]);
  assign vector_cmd_sr_option = optcfg_ff[`RTMC_OPT_VECTOR_BIT];
  assign reset_cmd_option     = optcfg_ff[`RTMC_OPT_RESET_BIT];

  // --------------------------------------------------------------------------
  // Mode command sequencer
  // --------------------------------------------------------------------------
  assign mc_known = i_mc_valid && is_handled_code(i_mc_code);

  // Next state: act on the command first, then let the status word go, then
  // reset the terminal if that was asked for.
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      RTMC_ST_IDLE: begin
        if (mc_known) begin
          nxt_state = RTMC_ST_PREP;
        end
      end
      RTMC_ST_PREP: begin
        if (!bcast_ff) begin
          nxt_state = RTMC_ST_STATUS;
        end else if (code_ff == `RTMC_MC_RESET_RT && !reset_cmd_option) begin
          nxt_state = RTMC_ST_RESET;
        end else begin
          nxt_state = RTMC_ST_IDLE;
        end
      end
      RTMC_ST_STATUS: begin
        if (go_sent_ff && i_status_done) begin
          if (code_ff == `RTMC_MC_RESET_RT && !reset_cmd_option) begin
            nxt_state = RTMC_ST_RESET;
          end else begin
            nxt_state = RTMC_ST_IDLE;
          end
        end
      end
      RTMC_ST_RESET: begin
        nxt_state = RTMC_ST_IDLE;
      end
    endcase
  end

  // A terminal soft reset or master reset abandons a command in progress.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= RTMC_ST_IDLE;
    end else if (mr_low || i_terminal_soft_reset) begin
      state_ff <= RTMC_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Command details are held for the whole sequence.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      code_ff  <= 5'h00;
      bcast_ff <= 1'b0;
      data_ff  <= 16'h0000;
    end else if (state_ff == RTMC_ST_IDLE && mc_known) begin
      code_ff  <= i_mc_code;
      bcast_ff <= i_mc_broadcast;
      data_ff  <= i_mc_data;
    end
  end

  // The status go pulse is issued once, one cycle after the load and clear
  // pulses, so the counter and status bits are settled before transmission.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      go_sent_ff   <= 1'b0;
      status_go_ff <= 1'b0;
    end else begin
      status_go_ff <= (state_ff == RTMC_ST_STATUS) && !go_sent_ff &&
                      !mr_low && !i_terminal_soft_reset;
      if (state_ff != RTMC_ST_STATUS) begin
        go_sent_ff <= 1'b0;
      end else begin
        go_sent_ff <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Action pulses
  // --------------------------------------------------------------------------
  // Counter load on synchronize with data word, gated by the option.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ttag_load_ff <= 1'b0;
      ttag_data_ff <= 16'h0000;
    end else begin
      ttag_load_ff <= (state_ff == RTMC_ST_PREP) && (code_ff == `RTMC_MC_SYNC_DATA) &&
                      sync_load_ok(sync_load_option, data_ff[0]);
      if (state_ff == RTMC_ST_PREP) begin
        ttag_data_ff <= data_ff;
      end
    end
  end
  // Service request clear on transmit vector word unless the host owns it.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sr_clear_ff <= 1'b0;
    end else begin
      sr_clear_ff <= (state_ff == RTMC_ST_PREP) && (code_ff == `RTMC_MC_TX_VECTOR) &&
                     !vector_cmd_sr_option;
    end
  end
  // Software reset pulse, only ever from the reset state.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      soft_reset_ff <= 1'b0;
    end else begin
      soft_reset_ff <= (state_ff == RTMC_ST_RESET);
    end
  end

  // Busy tells the protocol engine that a new command would be ignored.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= (nxt_state != RTMC_ST_IDLE) && !mr_low && !i_terminal_soft_reset;
    end
  end

  // --------------------------------------------------------------------------
  // Register read
  // --------------------------------------------------------------------------
  // Reads answer one cycle later; unmapped addresses read as zero.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_ff  <= 16'h0000;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= i_reg_rd;
      if (i_reg_rd) begin
        if (i_reg_addr == `RTMC_OPSTAT_ADDR) begin
          rdata_ff <= opstat_value;
        end else if (i_reg_addr == `RTMC_OPTCFG_ADDR) begin
          rdata_ff <= {12'h000, optcfg_ff};
        end else begin
          rdata_ff <= 16'h0000;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign o_reg_rdata          = rdata_ff;
  assign o_reg_rvalid         = rvalid_ff;
  assign o_mc_busy            = busy_ff;
  assign o_status_go          = status_go_ff;
  assign o_ttag_load          = ttag_load_ff;
  assign o_ttag_data          = ttag_data_ff;
  assign o_sr_clear           = sr_clear_ff;
  assign o_soft_reset_pulse   = soft_reset_ff;
  assign o_terminal_address   = addr_ff;
  assign o_address_parity_err = parity_err_ff;

endmodule : rtmc_mode_opt

//--- hw/rtmc_defines.svh
`ifndef RTMC_DEFINES_SVH
`define RTMC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define RTMC_ADDR_W            16
`define RTMC_DATA_W            16
`define RTMC_OPSTAT_ADDR       16'h0018
`define RTMC_OPTCFG_ADDR       16'h0017

// ----------------------------------------------------------------------------
// Option configuration fields
// ----------------------------------------------------------------------------
`define RTMC_OPT_SYNC_HI       3
`define RTMC_OPT_SYNC_LO       2
`define RTMC_OPT_VECTOR_BIT    1
`define RTMC_OPT_RESET_BIT     0
`define RTMC_OPTCFG_RESET      4'h0

// ----------------------------------------------------------------------------
// Operational status fields
// ----------------------------------------------------------------------------
`define RTMC_OPS_ADDR_HI       15
`define RTMC_OPS_ADDR_LO       11
`define RTMC_OPS_PARITY_BIT    10
`define RTMC_OPS_LOCK_BIT      9
`define RTMC_OPS_LOW_HI        8
`define RTMC_OPS_HIGH_W        7
`define RTMC_OPS_LOW_W         9
`define RTMC_OPS_LOW_RESET     9'h000

// ----------------------------------------------------------------------------
// Mode codes handled here
// ----------------------------------------------------------------------------
`define RTMC_MC_RESET_RT       5'h08
`define RTMC_MC_TX_VECTOR      5'h10
`define RTMC_MC_SYNC_DATA      5'h11

// ----------------------------------------------------------------------------
// Synchroniser depth for pins
// ----------------------------------------------------------------------------
`define RTMC_SYNC_STAGES       2

`endif

//--- hw/rtmc_pkg.sv
// ----------------------------------------------------------------------------
// Types of the mode command option logic
// ----------------------------------------------------------------------------
package rtmc_pkg;

  // Sequencer states of the mode command handler.
  typedef enum logic [1:0] {
    RTMC_ST_IDLE   = 2'b00,
    RTMC_ST_PREP   = 2'b01,
    RTMC_ST_STATUS = 2'b10,
    RTMC_ST_RESET  = 2'b11
  } rtmc_state_t;

  // Encodings of the synchronize load option.
  typedef enum logic [1:0] {
    RTMC_SYNC_HOST   = 2'b00,
    RTMC_SYNC_IF_LOW = 2'b01,
    RTMC_SYNC_IF_HI  = 2'b10,
    RTMC_SYNC_ALWAYS = 2'b11
  } rtmc_sync_opt_t;

endpackage : rtmc_pkg

//--- hw/rtmc_pin_sync.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Two flip-flop synchroniser for a group of asynchronous pins
// ----------------------------------------------------------------------------
module rtmc_pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // Pin side.
  input  wire logic [WIDTH-1:0] i_async,
  // Clock domain side.
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // The first stage feeds the second stage only, never any logic.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;

endmodule : rtmc_pin_sync

//--- hw/rtmc_opstat_reg.sv
`timescale 1ns/1ps
`include "rtmc_defines.svh"

// ----------------------------------------------------------------------------
// Operational status register storage
// ----------------------------------------------------------------------------
module rtmc_opstat_reg
  import rtmc_pkg::*;
(
  // Clock and reset.
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  // Master reset pin state, already synchronised.
  input  wire logic                        i_mr_low,
  input  wire logic                        i_mr_rise,
  input  wire logic [`RTMC_OPS_HIGH_W-1:0] i_pin_levels,
  // Host write.
  input  wire logic                        i_wr,
  input  wire logic [`RTMC_DATA_W-1:0]     i_wr_data,
  // Device owned low field.
  input  wire logic                        i_low_we,
  input  wire logic [`RTMC_OPS_LOW_W-1:0]  i_low_data,
  // Register contents.
  output logic      [`RTMC_DATA_W-1:0]     o_value
);

  logic [`RTMC_OPS_HIGH_W-1:0] high_ff;
  logic [`RTMC_OPS_LOW_W-1:0]  low_ff;

  // Address, parity and lock follow the pins at the end of master reset.
  // Afterwards the host may rewrite them only while the lock bit is clear.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      high_ff <= '0;
    end else if (i_mr_rise) begin
      high_ff <= i_pin_levels;
    end else if (i_wr && !high_ff[0]) begin
      high_ff <= i_wr_data[`RTMC_DATA_W-1:`RTMC_OPS_LOCK_BIT];
    end
  end

  // The low field ignores host writes and the terminal soft reset; only the
  // master reset pin clears it.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      low_ff <= `RTMC_OPS_LOW_RESET;
    end else if (i_mr_low) begin
      low_ff <= `RTMC_OPS_LOW_RESET;
    end else if (i_low_we) begin
      low_ff <= i_low_data;
    end
  end

  assign o_value = {high_ff, low_ff};

endmodule : rtmc_opstat_reg

//--- testbench/rtmc_mode_opt_properties.sv
`timescale 1ns/1ps
`include "rtmc_defines.svh"

// ----------------------------------------------------------------------------
// Port level checks of the mode command option logic
// ----------------------------------------------------------------------------
module rtmc_mode_opt_properties (
  // Clock, reset and requests.
  input wire logic                    i_clk,
  input wire logic                    i_rst,
  input wire logic                    i_reg_rd,
  input wire logic                    i_mc_valid,
  input wire logic [4:0]              i_mc_code,
  input wire logic                    i_mc_broadcast,
  input wire logic [`RTMC_DATA_W-1:0] i_mc_data,
  input wire logic                    i_status_done,
  // Answers of the block.
  input wire logic                    o_reg_rvalid,
  input wire logic                    o_mc_busy,
  input wire logic                    o_status_go,
  input wire logic                    o_ttag_load,
  input wire logic [`RTMC_DATA_W-1:0] o_ttag_data,
  input wire logic                    o_sr_clear,
  input wire logic                    o_soft_reset_pulse
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // Actions fire two edges after the command is taken.
  a_ttag_code: assert property (o_ttag_load |-> $past(i_mc_code, 2) == 5'h11)
    else $error("Time tag load without sync command.");
  a_ttag_value: assert property (o_ttag_load |-> o_ttag_data == $past(i_mc_data, 2))
    else $error("Time tag value differs from data word.");
  a_load_first: assert property (o_ttag_load && !$past(i_mc_broadcast, 2) |=> o_status_go)
    else $error("Status started before time tag load.");
  a_sr_code: assert property (o_sr_clear |-> $past(i_mc_code, 2) == 5'h10)
    else $error("Service request cleared without vector command.");
  a_sr_first: assert property (o_sr_clear && !$past(i_mc_broadcast, 2) |=> o_status_go)
    else $error("Status started before service request clear.");
  // Non-broadcast reset waits for the status word to leave.
  a_reset_late: assert property (o_soft_reset_pulse |-> $past(i_status_done, 2) ||
    $past(i_mc_valid, 3) && $past(i_mc_broadcast, 3))
    else $error("Soft reset not timed to status completion.");
  a_go_pulse: assert property (o_status_go |-> o_mc_busy ##1 !o_status_go)
    else $error("Status start is not a single pulse in a sequence.");
  a_read_answer: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("Register read not answered.");

  c_ttag: cover property (o_ttag_load);
  c_sr: cover property (o_sr_clear);
  c_reset: cover property (o_soft_reset_pulse);
endmodule : rtmc_mode_opt_properties

bind rtmc_mode_opt rtmc_mode_opt_properties u_props (.i_clk(i_clk), .i_rst(i_rst),
  .i_reg_rd(i_reg_rd), .i_mc_valid(i_mc_valid), .i_mc_code(i_mc_code),
  .i_mc_broadcast(i_mc_broadcast), .i_mc_data(i_mc_data), .i_status_done(i_status_done),
  .o_reg_rvalid(o_reg_rvalid), .o_mc_busy(o_mc_busy), .o_status_go(o_status_go),
  .o_ttag_load(o_ttag_load), .o_ttag_data(o_ttag_data), .o_sr_clear(o_sr_clear),
  .o_soft_reset_pulse(o_soft_reset_pulse));

//--- testbench/rtmc_bc_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Bus side model: sends the status word and reports its end
// ----------------------------------------------------------------------------
module rtmc_bc_model (
  // Clock and reset.
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Status request and pace.
  input  wire logic i_status_go,
  input  wire logic i_slow,
  // Transmission finished.
  output logic      o_status_done
);
  int cnt_ff;

  // The slow pace stretches the word so that late resets are exposed.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff        <= 0;
      o_status_done <= 1'b0;
    end else begin
      o_status_done <= (cnt_ff == 1);
      if (i_status_go) cnt_ff <= i_slow ? 9 : 3;
      else if (cnt_ff != 0) cnt_ff <= cnt_ff - 1;
    end
  end
endmodule : rtmc_bc_model

//--- testbench/tb_rtmc_mode_opt.sv
`timescale 1ns/1ps
`include "rtmc_defines.svh"

// ----------------------------------------------------------------------------
// Self-checking bench of the mode command option logic
// ----------------------------------------------------------------------------
module tb_rtmc_mode_opt;
  logic        i_clk, i_rst, mr_n, lock, par, rd, wr, srst, mcv, bc, done, lwe, slow;
  logic        rv, busy, go, ld, src, rp, perr;
  logic [4:0]  ta, code, t_addr;
  logic [8:0]  lst;
  logic [15:0] addr, wd, rdata, mdata, tdata;
  int          n_mismatch, checks_done, n_ld, n_sr, n_rp, n_go;

  rtmc_mode_opt dut (.i_clk(i_clk), .i_rst(i_rst), .i_master_reset_n(mr_n),
    .i_terminal_address(ta), .i_terminal_address_parity(par), .i_address_lock(lock),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wd),
    .o_reg_rdata(rdata), .o_reg_rvalid(rv), .i_terminal_soft_reset(srst),
    .i_mc_valid(mcv), .i_mc_code(code), .i_mc_broadcast(bc), .i_mc_data(mdata),
    .o_mc_busy(busy), .o_status_go(go), .i_status_done(done), .o_ttag_load(ld),
    .o_ttag_data(tdata), .o_sr_clear(src), .o_soft_reset_pulse(rp),
    .i_low_status_we(lwe), .i_low_status(lst), .o_terminal_address(t_addr),
    .o_address_parity_err(perr));
  rtmc_bc_model u_bc (.i_clk(i_clk), .i_rst(i_rst), .i_status_go(go), .i_slow(slow),
    .o_status_done(done));

  // Clock at 40 MHz.
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // Pulses are counted mid-cycle, away from the launching edge.
  always @(negedge i_clk) begin
    n_ld = n_ld + int'(ld);
    n_sr = n_sr + int'(src);
    n_rp = n_rp + int'(rp);
    n_go = n_go + int'(go);
  end

  task automatic stop_test;
    $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic wreg(input logic [15:0] a, input logic [15:0] d);
    @(posedge i_clk) {wr, addr, wd} <= {1'b1, a, d};
    @(posedge i_clk) wr <= 1'b0;
  endtask : wreg

  // Read latency is fixed at one cycle.
  task automatic rchk(input logic [15:0] a, input logic [15:0] e);
    @(posedge i_clk) {rd, addr} <= {1'b1, a};
    @(posedge i_clk) rd <= 1'b0;
    #1;
    chk({15'h0, rv}, 16'h0001);
    chk(rdata, e);
  endtask : rchk

  // Pin capture needs the strap levels steady around the rising edge.
  task automatic mres(input logic [4:0] a, input logic p, input logic l);
    @(posedge i_clk) {mr_n, ta, par, lock} <= {1'b0, a, p, l};
    repeat (4) @(posedge i_clk);
    mr_n <= 1'b1;
    repeat (6) @(posedge i_clk);
  endtask : mres

  task automatic mc(input logic [4:0] c, input logic b, input logic [15:0] d,
                    input int eld, input int esr, input int erp);
    int k, l0, s0, r0, g0;
    l0 = n_ld;
    s0 = n_sr;
    r0 = n_rp;
    g0 = n_go;
    @(posedge i_clk) {mcv, code, bc, mdata} <= {1'b1, c, b, d};
    @(posedge i_clk) mcv <= 1'b0;
    repeat (2) @(posedge i_clk);
    for (k = 0; k < 40 && busy !== 1'b0; k++) @(posedge i_clk);
    if (k == 40) begin
      n_mismatch++;
      stop_test();
    end
    repeat (3) @(posedge i_clk);
    chk(16'(n_ld - l0), 16'(eld));
    chk(16'(n_sr - s0), 16'(esr));
    chk(16'(n_rp - r0), 16'(erp));
    chk(16'(n_go - g0), 16'(!b));
    if (eld != 0) chk(tdata, d);
  endtask : mc

  task automatic t_ops;
    rchk(`RTMC_OPSTAT_ADDR, 16'h9800);
    chk({11'h0, t_addr}, 16'h0013);
    chk({15'h0, perr}, 16'h0000);
    @(posedge i_clk) {lwe, lst} <= {1'b1, 9'h1a5};
    @(posedge i_clk) {lwe, srst} <= 2'b01;
    @(posedge i_clk) srst <= 1'b0;
    rchk(`RTMC_OPSTAT_ADDR, 16'h99a5);
    wreg(`RTMC_OPSTAT_ADDR, 16'h0000);
    rchk(`RTMC_OPSTAT_ADDR, 16'h01a5);
    chk({15'h0, perr}, 16'h0001);
    wreg(`RTMC_OPSTAT_ADDR, 16'hfe00);
    wreg(`RTMC_OPSTAT_ADDR, 16'h0000);
    rchk(`RTMC_OPSTAT_ADDR, 16'hffa5);
    rchk(16'h0040, 16'h0000);
    mres(5'h0a, 1'b1, 1'b1);
    rchk(`RTMC_OPSTAT_ADDR, 16'h5600);
    wreg(`RTMC_OPSTAT_ADDR, 16'h0000);
    rchk(`RTMC_OPSTAT_ADDR, 16'h5600);
    mres(5'h13, 1'b0, 1'b0);
    wreg(`RTMC_OPSTAT_ADDR, 16'h0400);
    rchk(`RTMC_OPSTAT_ADDR, 16'h0400);
  endtask : t_ops

  // Every sync option against both values of data bit 0.
  task automatic t_sync;
    for (int o = 0; o < 4; o++) begin
      for (int b = 0; b < 2; b++) begin
        wreg(`RTMC_OPTCFG_ADDR, 16'(o << 2));
        slow <= b[0];
        mc(5'h11, 1'b0, 16'ha5a4 | 16'(b), int'(o == 3 || o == 1 && b == 0 || o == 2 && b == 1),
           0, 0);
      end
    end
    mc(5'h11, 1'b1, 16'h1234, 1, 0, 0);
  endtask : t_sync

  task automatic t_vec;
    for (int v = 0; v < 2; v++) begin
      wreg(`RTMC_OPTCFG_ADDR, 16'(v << 1));
      mc(5'h10, 1'b0, 16'h0, 0, int'(v == 0), 0);
    end
  endtask : t_vec

  task automatic t_rst;
    for (int r = 0; r < 4; r++) begin
      wreg(`RTMC_OPTCFG_ADDR, 16'(r & 1));
      mc(5'h08, r[1], 16'h0, 0, 0, int'(r[0] == 1'b0));
    end
  endtask : t_rst

  initial begin
    {i_rst, mr_n, ta, par, lock} = {1'b1, 1'b0, 5'h13, 2'b00};
    {rd, wr, srst, mcv, bc, lwe, slow} = '0;
    {code, addr, wd, mdata, lst} = '0;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    mres(5'h13, 1'b0, 1'b0);
    t_ops();
    t_sync();
    t_vec();
    t_rst();
    stop_test();
  end
endmodule : tb_rtmc_mode_opt
